//--- verilog/sysc_pkg.sv
// Constants for the system-control interrupt and clock-gating block.
// Assumes a 40 MHz system clock and a simple strobed register port.
package sysc_pkg;

  // ==========================================================
  // Register offsets (byte addresses)
  // ==========================================================
  localparam logic [7:0] OFS_RAW = 8'h00;
  localparam logic [7:0] OFS_IEN = 8'h04;
  localparam logic [7:0] OFS_MASKED = 8'h08;
  localparam logic [7:0] OFS_CLR = 8'h0C;
  localparam logic [7:0] OFS_LDO_VSEL = 8'h10;
  localparam logic [7:0] OFS_LDO_CFG = 8'h14;
  localparam logic [7:0] OFS_VERIFY = 8'h18;
  localparam logic [7:0] OFS_GATE = 8'h1C;
  localparam logic [7:0] OFS_RUN_EN = 8'h20;
  localparam logic [7:0] OFS_SLEEP_EN = 8'h24;
  localparam logic [7:0] OFS_DEEP_EN = 8'h28;

  // ==========================================================
  // Interrupt source bit positions
  // ==========================================================
  localparam int NSRC = 7;
  localparam int BIT_PLL_LOCKED = 0;
  localparam int BIT_REG_OVERCURRENT = 1;
  localparam int BIT_INT_OSC_FAIL = 2;
  localparam int BIT_MAIN_OSC_FAIL = 3;
  localparam int BIT_REG_DROOP = 4;
  localparam int BIT_SUPPLY_DROOP = 5;
  localparam int BIT_PLL_FAILURE = 6;

  // ==========================================================
  // Control fields
  // ==========================================================
  localparam int VERIFY_MAIN_BIT = 0;
  localparam int VERIFY_INT_BIT = 1;
  localparam int NPERIPH = 31;

  // Voltage code: 0 is nominal, 1..5 step up, 0xB..0xF step down.
  localparam int VSEL_W = 4;
  localparam logic [3:0] VSEL_RST = 4'h0;
  localparam logic [3:0] VSEL_MAX_UP = 4'h5;
  localparam logic [3:0] VSEL_MIN_DN = 4'hB;

  // Reference edges without a monitored edge before a failure.
  localparam logic [7:0] OSC_REF_EDGES = 8'h10;

endpackage

//--- verilog/sys_ctrl_gate.sv
// System-control interrupt collector, oscillator checkers, regulator
// control and sleep clock gating. Assumes oscillator and fault inputs
// are asynchronous, and the power-mode inputs come from the MCLK domain.
//
// Contract
// - Seven fault and lock events raise sources.
// - Raw and masked status are both readable.
// - Pending source stays until software clears.
// - Internal oscillator stop flags when checking enabled.
// - Main oscillator is the internal one's reference.
// - Main oscillator stop flags when checking enabled.
// - Internal oscillator is the main one's reference.
// - Regulator failure may request processor reset.
// - Voltage field resets to nominal, within ten percent.
// - Voltage readback returns the control field.
// - Gating off clocks peripherals as in run.
// - Gating on follows sleep or deep-sleep bits.
// - Sleep bits kept but ignored while gating off.
// - Deep-sleep disabled peripheral stops, state kept.
// - Deep-sleep enabled peripheral keeps running.
// - Separate sleep and deep-sleep bits per peripheral.
// - Per-source enable gates the interrupt.
// - Masked clear drops only selected sources.
//
// The address map and the strobed register port were chosen for this implementation.
`timescale 1ns/1ps

module sys_ctrl_gate #(
  parameter int NPERIPH = sysc_pkg::NPERIPH,
  parameter logic [7:0] OSC_REF_EDGES = sysc_pkg::OSC_REF_EDGES
) (
  input wire logic MCLK,
  input wire logic RST,
  input wire logic [7:0] REG_ADDR,
  input wire logic [31:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output logic [31:0] REG_RDATA,
  input wire logic PLL_LOCK_IN,
  input wire logic REG_OVERCURRENT_IN,
  input wire logic REG_DROOP_IN,
  input wire logic SUPPLY_DROOP_IN,
  input wire logic PLL_FAIL_IN,
  input wire logic REG_UNREGULATED_IN,
  input wire logic MAIN_OSC_CLK,
  input wire logic INT_OSC_CLK,
  input wire logic MAIN_OSC_ON,
  input wire logic INT_OSC_ON,
  input wire logic SLEEP_MODE,
  input wire logic DEEP_SLEEP_MODE,
  output logic IRQ,
  output logic [NPERIPH-1:0] PERIPH_CLK_EN,
  output logic [3:0] LDO_VSEL,
  output logic LDO_RESET_REQ
);

  // ==========================================================
  // State
  // ==========================================================
  typedef struct packed {
    logic [4:0] ev_s1;
    logic [4:0] ev_s2;
    logic [4:0] ev_s3;
    logic [1:0] osc_s1;
    logic [1:0] osc_s2;
    logic [1:0] osc_s3;
    logic unreg_s1;
    logic unreg_s2;
    logic [7:0] cnt0;
    logic [7:0] cnt1;
    logic [6:0] raw;
    logic [6:0] ien;
    logic [3:0] vsel;
    logic ldo_cfg;
    logic [1:0] verify;
    logic gate;
    logic [NPERIPH-1:0] run_en;
    logic [NPERIPH-1:0] sleep_en;
    logic [NPERIPH-1:0] deep_en;
    logic [31:0] rdata;
    logic irq;
    logic [NPERIPH-1:0] clk_en;
    logic ldo_rst;
  } state_s;

  state_s st_q;
  state_s st_d;
  logic [4:0] ext_rise;
  logic [1:0] osc_rise;
  logic [1:0] fail;
  logic [6:0] set_v;
  logic [6:0] clr_v;
  logic chk_on;
  logic [NPERIPH-1:0] mode_mask;

  // ==========================================================
  // Next-state logic
  // ==========================================================
  always_comb begin
    st_d = st_q;
    // Pins are asynchronous: two stages before any logic reads them.
    st_d.ev_s1 = {PLL_FAIL_IN, SUPPLY_DROOP_IN, REG_DROOP_IN,
                  REG_OVERCURRENT_IN, PLL_LOCK_IN};
    st_d.ev_s2 = st_q.ev_s1;
    st_d.ev_s3 = st_q.ev_s2;
    st_d.osc_s1 = {INT_OSC_CLK, MAIN_OSC_CLK};
    st_d.osc_s2 = st_q.osc_s1;
    st_d.osc_s3 = st_q.osc_s2;
    st_d.unreg_s1 = REG_UNREGULATED_IN;
    st_d.unreg_s2 = st_q.unreg_s1;
    ext_rise = st_q.ev_s2 & ~st_q.ev_s3;
    osc_rise = st_q.osc_s2 & ~st_q.osc_s3;

    // Each oscillator is timed against the other, so neither check
    // can run unless both oscillators are on.
    chk_on = MAIN_OSC_ON & INT_OSC_ON;
    fail = 2'b00;
    // Main oscillator, counted in internal-oscillator edges.
    if (!(st_q.verify[sysc_pkg::VERIFY_MAIN_BIT] && chk_on) ||
        osc_rise[0]) begin
      st_d.cnt0 = 8'h00;
    end else if (osc_rise[1] && st_q.cnt0 != OSC_REF_EDGES) begin
      st_d.cnt0 = st_q.cnt0 + 8'h01;
      fail[0] = (st_q.cnt0 == OSC_REF_EDGES - 8'h01);
    end
    // Internal oscillator, counted in main-oscillator edges.
    if (!(st_q.verify[sysc_pkg::VERIFY_INT_BIT] && chk_on) ||
        osc_rise[1]) begin
      st_d.cnt1 = 8'h00;
    end else if (osc_rise[0] && st_q.cnt1 != OSC_REF_EDGES) begin
      st_d.cnt1 = st_q.cnt1 + 8'h01;
      fail[1] = (st_q.cnt1 == OSC_REF_EDGES - 8'h01);
    end

    set_v = '0;
    set_v[sysc_pkg::BIT_PLL_LOCKED] = ext_rise[0];
    set_v[sysc_pkg::BIT_REG_OVERCURRENT] = ext_rise[1];
    set_v[sysc_pkg::BIT_INT_OSC_FAIL] = fail[1];
    set_v[sysc_pkg::BIT_MAIN_OSC_FAIL] = fail[0];
    set_v[sysc_pkg::BIT_REG_DROOP] = ext_rise[2];
    set_v[sysc_pkg::BIT_SUPPLY_DROOP] = ext_rise[3];
    set_v[sysc_pkg::BIT_PLL_FAILURE] = ext_rise[4];

    clr_v = '0;
    if (REG_WR && REG_ADDR == sysc_pkg::OFS_CLR) begin
      clr_v = REG_WDATA[6:0];
    end
    // A new event in the clearing cycle wins over the clear.
    st_d.raw = (st_q.raw & ~clr_v) | set_v;

    if (REG_WR) begin
      case (REG_ADDR)
        sysc_pkg::OFS_IEN: st_d.ien = REG_WDATA[6:0];
        sysc_pkg::OFS_LDO_VSEL: begin
          // Codes outside the nominal +/-10% span are ignored.
          if (REG_WDATA[3:0] <= sysc_pkg::VSEL_MAX_UP ||
              REG_WDATA[3:0] >= sysc_pkg::VSEL_MIN_DN) begin
            st_d.vsel = REG_WDATA[3:0];
          end
        end
        sysc_pkg::OFS_LDO_CFG: st_d.ldo_cfg = REG_WDATA[0];
        sysc_pkg::OFS_VERIFY: st_d.verify = REG_WDATA[1:0];
        sysc_pkg::OFS_GATE: st_d.gate = REG_WDATA[0];
        sysc_pkg::OFS_RUN_EN: st_d.run_en = REG_WDATA[NPERIPH-1:0];
        sysc_pkg::OFS_SLEEP_EN: st_d.sleep_en = REG_WDATA[NPERIPH-1:0];
        sysc_pkg::OFS_DEEP_EN: st_d.deep_en = REG_WDATA[NPERIPH-1:0];
        default: st_d.ien = st_d.ien;
      endcase
    end

    st_d.rdata = 32'h0000_0000;
    if (REG_RD) begin
      case (REG_ADDR)
        sysc_pkg::OFS_RAW: st_d.rdata[6:0] = st_q.raw;
        sysc_pkg::OFS_IEN: st_d.rdata[6:0] = st_q.ien;
        sysc_pkg::OFS_MASKED: st_d.rdata[6:0] = st_q.raw & st_q.ien;
        sysc_pkg::OFS_LDO_VSEL: st_d.rdata[3:0] = st_q.vsel;
        sysc_pkg::OFS_LDO_CFG: st_d.rdata[0] = st_q.ldo_cfg;
        sysc_pkg::OFS_VERIFY: st_d.rdata[1:0] = st_q.verify;
        sysc_pkg::OFS_GATE: st_d.rdata[0] = st_q.gate;
        sysc_pkg::OFS_RUN_EN: st_d.rdata[NPERIPH-1:0] = st_q.run_en;
        sysc_pkg::OFS_SLEEP_EN: st_d.rdata[NPERIPH-1:0] = st_q.sleep_en;
        sysc_pkg::OFS_DEEP_EN: st_d.rdata[NPERIPH-1:0] = st_q.deep_en;
        default: st_d.rdata = 32'h0000_0000;
      endcase
    end

    st_d.irq = |(st_d.raw & st_d.ien);

    // Sleep and deep-sleep masks are only consulted with gating on;
    // the bits themselves are never touched by a mode change.
    mode_mask = '1;
    if (st_q.gate) begin
      if (DEEP_SLEEP_MODE) begin
        mode_mask = st_q.deep_en;
      end else if (SLEEP_MODE) begin
        mode_mask = st_q.sleep_en;
      end
    end
    // Only the clock is removed, so a stopped peripheral resumes
    // with its state intact when the mode ends.
    st_d.clk_en = st_q.run_en & mode_mask;
    st_d.ldo_rst = st_q.ldo_cfg & st_q.unreg_s2;
  end

  // ==========================================================
  // Registers
  // ==========================================================
  always_ff @(posedge MCLK) begin
    if (RST) begin
      st_q <= '0;
      st_q.vsel <= sysc_pkg::VSEL_RST;
    end else begin
      st_q <= st_d;
    end
  end

  assign REG_RDATA = st_q.rdata;
  assign IRQ = st_q.irq;
  assign PERIPH_CLK_EN = st_q.clk_en;
  assign LDO_VSEL = st_q.vsel;
  assign LDO_RESET_REQ = st_q.ldo_rst;

  // ==========================================================
  // Assertions
  // ==========================================================
  property p_event_sets;
    @(posedge MCLK) disable iff (RST)
    (st_q.ev_s2[4] && !st_q.ev_s3[4]) |=>
      st_q.raw[sysc_pkg::BIT_PLL_FAILURE];
  endproperty
  a_event_sets: assert property (p_event_sets)
    else $error("pll failure edge did not set its flag");

  property p_masked_read;
    @(posedge MCLK) disable iff (RST)
    (REG_RD && REG_ADDR == sysc_pkg::OFS_MASKED) |=>
      REG_RDATA == {25'h0, $past(st_q.raw) & $past(st_q.ien)};
  endproperty
  a_masked_read: assert property (p_masked_read)
    else $error("masked status read wrong");

  property p_sticky;
    @(posedge MCLK) disable iff (RST)
    (st_q.raw[0] && !(REG_WR && REG_ADDR == sysc_pkg::OFS_CLR))
      |=> st_q.raw[0] [*1];
  endproperty
  a_sticky: assert property (p_sticky)
    else $error("pending flag dropped without a clear");

  property p_clear;
    @(posedge MCLK) disable iff (RST)
    (REG_WR && REG_ADDR == sysc_pkg::OFS_CLR && REG_WDATA[5] &&
     !(st_q.ev_s2[3] && !st_q.ev_s3[3])) |=> !st_q.raw[5];
  endproperty
  a_clear: assert property (p_clear)
    else $error("selected flag not cleared");

  property p_main_off;
    @(posedge MCLK) disable iff (RST)
    (!st_q.verify[sysc_pkg::VERIFY_MAIN_BIT] &&
     !st_q.raw[sysc_pkg::BIT_MAIN_OSC_FAIL]) |=>
      !st_q.raw[sysc_pkg::BIT_MAIN_OSC_FAIL];
  endproperty
  a_main_off: assert property (p_main_off)
    else $error("main oscillator failure raised while unchecked");

  property p_int_needs_both;
    @(posedge MCLK) disable iff (RST)
    (!(MAIN_OSC_ON && INT_OSC_ON) &&
     !st_q.raw[sysc_pkg::BIT_INT_OSC_FAIL]) |=>
      !st_q.raw[sysc_pkg::BIT_INT_OSC_FAIL];
  endproperty
  a_int_needs_both: assert property (p_int_needs_both)
    else $error("internal oscillator check ran without both on");

  property p_ldo_reset;
    @(posedge MCLK) disable iff (RST)
    LDO_RESET_REQ |-> $past(st_q.ldo_cfg) && $past(st_q.unreg_s2);
  endproperty
  a_ldo_reset: assert property (p_ldo_reset)
    else $error("reset requested without cause");

  property p_vsel_reset;
    @(posedge MCLK) $fell(RST) |-> LDO_VSEL == sysc_pkg::VSEL_RST;
  endproperty
  a_vsel_reset: assert property (p_vsel_reset)
    else $error("voltage field not nominal after reset");

  property p_vsel_read;
    @(posedge MCLK) disable iff (RST)
    (REG_RD && REG_ADDR == sysc_pkg::OFS_LDO_VSEL) |=>
      REG_RDATA[3:0] == $past(LDO_VSEL);
  endproperty
  a_vsel_read: assert property (p_vsel_read)
    else $error("voltage readback differs from field");

  property p_ungated;
    @(posedge MCLK) disable iff (RST)
    !st_q.gate |=> PERIPH_CLK_EN == $past(st_q.run_en);
  endproperty
  a_ungated: assert property (p_ungated)
    else $error("clocks changed with gating off");

  property p_deep;
    @(posedge MCLK) disable iff (RST)
    (st_q.gate && DEEP_SLEEP_MODE) |=>
      PERIPH_CLK_EN == ($past(st_q.run_en) & $past(st_q.deep_en));
  endproperty
  a_deep: assert property (p_deep)
    else $error("deep-sleep clocks do not follow enables");

  property p_irq;
    @(posedge MCLK) disable iff (RST)
    IRQ == |(st_q.raw & st_q.ien);
  endproperty
  a_irq: assert property (p_irq)
    else $error("interrupt line disagrees with masked status");

  property p_overcurrent_sets;
    @(posedge MCLK) disable iff (RST)
    (st_q.ev_s2[1] && !st_q.ev_s3[1]) |=>
      st_q.raw[sysc_pkg::BIT_REG_OVERCURRENT];
  endproperty
  a_overcurrent_sets: assert property (p_overcurrent_sets)
    else $error("overcurrent edge did not set its flag");

  property p_int_off;
    @(posedge MCLK) disable iff (RST)
    (!st_q.verify[sysc_pkg::VERIFY_INT_BIT] &&
     !st_q.raw[sysc_pkg::BIT_INT_OSC_FAIL]) |=>
      !st_q.raw[sysc_pkg::BIT_INT_OSC_FAIL];
  endproperty
  a_int_off: assert property (p_int_off)
    else $error("internal oscillator failure raised while unchecked");

  property p_main_needs_both;
    @(posedge MCLK) disable iff (RST)
    (!(MAIN_OSC_ON && INT_OSC_ON) &&
     !st_q.raw[sysc_pkg::BIT_MAIN_OSC_FAIL]) |=>
      !st_q.raw[sysc_pkg::BIT_MAIN_OSC_FAIL];
  endproperty
  a_main_needs_both: assert property (p_main_needs_both)
    else $error("main oscillator check ran without both on");

  property p_ldo_no_reset;
    @(posedge MCLK) disable iff (RST)
    !st_q.ldo_cfg |=> !LDO_RESET_REQ;
  endproperty
  a_ldo_no_reset: assert property (p_ldo_no_reset)
    else $error("reset requested with the reset choice off");

  property p_sleep;
    @(posedge MCLK) disable iff (RST)
    (st_q.gate && SLEEP_MODE && !DEEP_SLEEP_MODE) |=>
      PERIPH_CLK_EN == ($past(st_q.run_en) & $past(st_q.sleep_en));
  endproperty
  a_sleep: assert property (p_sleep)
    else $error("sleep clocks do not follow enables");

  property p_bits_kept;
    @(posedge MCLK) disable iff (RST)
    (!st_q.gate && !(REG_WR && (REG_ADDR == sysc_pkg::OFS_SLEEP_EN ||
     REG_ADDR == sysc_pkg::OFS_DEEP_EN))) |=>
      st_q.sleep_en == $past(st_q.sleep_en) &&
      st_q.deep_en == $past(st_q.deep_en);
  endproperty
  a_bits_kept: assert property (p_bits_kept)
    else $error("sleep enables changed without a write");

  property p_disabled_quiet;
    @(posedge MCLK) disable iff (RST)
    (st_q.ien == 7'h00) |-> !IRQ;
  endproperty
  a_disabled_quiet: assert property (p_disabled_quiet)
    else $error("interrupt raised with every source disabled");

endmodule

//--- test/osc_model.sv
// Behavioural oscillator pair that the block watches.
// Assumes MCLK is the system clock; a stopped oscillator holds its level.
`timescale 1ns/1ps

module osc_model (
  input wire logic MCLK,
  input wire logic MAIN_RUN,
  input wire logic INT_RUN,
  output logic MAIN_CLK,
  output logic INT_CLK
);
  logic [2:0] div_q = 3'h0;
  logic main_q = 1'b0;
  logic int_q = 1'b0;

  // A real oscillator that dies simply freezes, so it holds its level.
  always @(posedge MCLK) begin
    div_q <= div_q + 3'h1;
    if (MAIN_RUN && div_q[1:0] == 2'h3) begin
      main_q <= ~main_q;
    end
    if (INT_RUN && div_q == 3'h7) begin
      int_q <= ~int_q;
    end
  end

  assign MAIN_CLK = main_q;
  assign INT_CLK = int_q;
endmodule

//--- test/tb_top.sv
// Self-checking bench for the system-control block.
// Assumes the strobed register port and a 4-edge oscillator check.
`timescale 1ns/1ps

module tb_top;
  typedef struct packed {
    logic [7:0] a;
    logic [31:0] d;
    logic [31:0] e;
  } row_s;
  logic mclk, rst, wr, rd, unreg, mon, ion, slp, dslp, mrun, irun;
  logic mck, ick, irq, ldo_rst;
  logic [7:0] addr;
  logic [31:0] wdata, rdata;
  logic [4:0] ev;
  logic [30:0] pce;
  logic [3:0] vsel;
  int num_errors, check_count;
  int evbit[5] = '{0, 1, 4, 5, 6};
  row_s rows[8] = '{
    '{sysc_pkg::OFS_IEN, 32'h7F, 32'h7F},
    '{sysc_pkg::OFS_LDO_VSEL, 32'h5, 32'h5},
    '{sysc_pkg::OFS_LDO_VSEL, 32'h7, 32'h5},
    '{sysc_pkg::OFS_LDO_VSEL, 32'hB, 32'hB},
    '{sysc_pkg::OFS_LDO_CFG, 32'h1, 32'h1},
    '{sysc_pkg::OFS_CLR, 32'h7F, 32'h0},
    '{8'h3C, 32'hFFFFFFFF, 32'h0},
    '{sysc_pkg::OFS_RUN_EN, 32'hFFFFFFFF, 32'h7FFFFFFF}};

  sys_ctrl_gate #(.OSC_REF_EDGES(8'h04)) u_dut (
    .MCLK(mclk), .RST(rst), .REG_ADDR(addr), .REG_WDATA(wdata),
    .REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdata),
    .PLL_LOCK_IN(ev[0]), .REG_OVERCURRENT_IN(ev[1]),
    .REG_DROOP_IN(ev[2]), .SUPPLY_DROOP_IN(ev[3]), .PLL_FAIL_IN(ev[4]),
    .REG_UNREGULATED_IN(unreg), .MAIN_OSC_CLK(mck), .INT_OSC_CLK(ick),
    .MAIN_OSC_ON(mon), .INT_OSC_ON(ion), .SLEEP_MODE(slp),
    .DEEP_SLEEP_MODE(dslp), .IRQ(irq), .PERIPH_CLK_EN(pce),
    .LDO_VSEL(vsel), .LDO_RESET_REQ(ldo_rst));

  osc_model u_osc (.MCLK(mclk), .MAIN_RUN(mrun), .INT_RUN(irun),
    .MAIN_CLK(mck), .INT_CLK(ick));

  // ==========================================================
  // Shared tasks
  // ==========================================================
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Called just after an edge; one idle cycle follows each strobe.
  task wr_reg(input logic [7:0] a, input logic [31:0] d);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge mclk);
    wr <= 1'b0;
    @(posedge mclk);
  endtask

  task rd_chk(input logic [7:0] a, input logic [31:0] e);
    rd <= 1'b1;
    addr <= a;
    @(posedge mclk);
    rd <= 1'b0;
    #1 chk(rdata, e);
    @(posedge mclk);
  endtask

  task osc_case(input logic [31:0] v, input logic m, input logic sm,
                input logic si, input logic [31:0] e);
    wr_reg(sysc_pkg::OFS_VERIFY, v);
    mon <= m;
    mrun <= ~sm;
    irun <= ~si;
    repeat (150) @(posedge mclk);
    rd_chk(sysc_pkg::OFS_RAW, e);
    mrun <= 1'b1;
    irun <= 1'b1;
    mon <= 1'b1;
    repeat (40) @(posedge mclk);
    wr_reg(sysc_pkg::OFS_CLR, 32'h7F);
  endtask

  task complete_run();
    $display("checks=%0d errors=%0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // ==========================================================
  // Clock, watchdog and main sequence
  // ==========================================================
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  initial begin
    repeat (20000) @(posedge mclk);
    num_errors++;
    complete_run();
  end

  initial begin
    {rst, wr, rd, unreg, slp, dslp} = 6'h20;
    {mon, ion, mrun, irun} = 4'hF;
    addr = 8'h00;
    wdata = 32'h0;
    ev = 5'h00;
    num_errors = 0;
    check_count = 0;
    repeat (8) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    rd_chk(sysc_pkg::OFS_LDO_VSEL, 32'h0);
    chk({31'h0, irq}, 32'h0);
    $display("reset test done");
    foreach (rows[i]) begin
      wr_reg(rows[i].a, rows[i].d);
      rd_chk(rows[i].a, rows[i].e);
    end
    chk({28'h0, vsel}, 32'hB);
    $display("register rows done");
    for (int i = 0; i < 5; i++) begin
      ev[i] <= 1'b1;
      repeat (5) @(posedge mclk);
      chk({31'h0, irq}, 32'h1);
      rd_chk(sysc_pkg::OFS_RAW, 32'h1 << evbit[i]);
      wr_reg(sysc_pkg::OFS_CLR, 32'h1 << evbit[i]);
      ev[i] <= 1'b0;
      chk({31'h0, irq}, 32'h0);
    end
    $display("event test done");
    // The failure pin must be seen low once, or no new edge follows.
    @(posedge mclk);
    ev <= 5'h11;
    wr_reg(sysc_pkg::OFS_IEN, 32'h01);
    repeat (4) @(posedge mclk);
    rd_chk(sysc_pkg::OFS_MASKED, 32'h01);
    rd_chk(sysc_pkg::OFS_RAW, 32'h41);
    wr_reg(sysc_pkg::OFS_CLR, 32'h01);
    repeat (20) @(posedge mclk);
    rd_chk(sysc_pkg::OFS_RAW, 32'h40);
    chk({31'h0, irq}, 32'h0);
    wr_reg(sysc_pkg::OFS_IEN, 32'h40);
    chk({31'h0, irq}, 32'h1);
    wr_reg(sysc_pkg::OFS_CLR, 32'h40);
    ev <= 5'h00;
    $display("mask and clear test done");
    osc_case(32'h0, 1'b1, 1'b1, 1'b0, 32'h0);
    osc_case(32'h1, 1'b1, 1'b1, 1'b0, 32'h8);
    osc_case(32'h2, 1'b1, 1'b0, 1'b1, 32'h4);
    osc_case(32'h2, 1'b0, 1'b0, 1'b1, 32'h0);
    $display("oscillator test done");
    wr_reg(sysc_pkg::OFS_SLEEP_EN, 32'h2AAAAAAA);
    wr_reg(sysc_pkg::OFS_DEEP_EN, 32'h55555555);
    slp <= 1'b1;
    repeat (3) @(posedge mclk);
    chk({1'b0, pce}, 32'h7FFFFFFF);
    wr_reg(sysc_pkg::OFS_GATE, 32'h1);
    // The clock enables follow a control write one cycle later.
    @(posedge mclk);
    chk({1'b0, pce}, 32'h2AAAAAAA);
    dslp <= 1'b1;
    repeat (3) @(posedge mclk);
    chk({1'b0, pce}, 32'h55555555);
    wr_reg(sysc_pkg::OFS_RUN_EN, 32'h0000FFFF);
    @(posedge mclk);
    chk({1'b0, pce}, 32'h00005555);
    {slp, dslp} <= 2'h0;
    repeat (3) @(posedge mclk);
    chk({1'b0, pce}, 32'h0000FFFF);
    wr_reg(sysc_pkg::OFS_GATE, 32'h0);
    rd_chk(sysc_pkg::OFS_SLEEP_EN, 32'h2AAAAAAA);
    $display("gating test done");
    unreg <= 1'b1;
    repeat (6) @(posedge mclk);
    chk({31'h0, ldo_rst}, 32'h1);
    wr_reg(sysc_pkg::OFS_LDO_CFG, 32'h0);
    repeat (2) @(posedge mclk);
    chk({31'h0, ldo_rst}, 32'h0);
    $display("regulator test done");
    rst <= 1'b1;
    repeat (3) @(posedge mclk);
    rst <= 1'b0;
    repeat (2) @(posedge mclk);
    chk({28'h0, vsel}, 32'h0);
    chk({1'b0, pce}, 32'h0);
    rd_chk(sysc_pkg::OFS_LDO_VSEL, 32'h0);
    $display("mid-run reset test done");
    complete_run();
  end
endmodule
